// ==== pscp_alert.v ====
`timescale 1ns/1ps
`include "pscp_regs.vh"
// alert pulse timer: a trigger starts a fixed-length low pulse
module pscp_alert (
  input wire clk,
  input wire reset_n,
  input wire trigger,
  output wire busy
);
  // the product is a 32-bit integer; keep only the counter's width
  localparam integer ALERT_INT = `PSCP_ALERT_CYC;
  localparam [11:0] ALERT_CYC = ALERT_INT[11:0];
  reg [11:0] cnt_q;
  // retrigger restarts the full length so no change is shortened
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 12'h000;
    end else if (trigger) begin
      cnt_q <= ALERT_CYC;
    end else if (cnt_q != 12'h000) begin
      cnt_q <= cnt_q - 12'h001;
    end
  end
  assign busy = (cnt_q != 12'h000);
endmodule // pscp_alert

// ==== pscp_host_model.sv ====
`timescale 1ns/1ps
// bus controller; scl idles high and stands still outside frames
module pscp_host_model (
  output logic scl,
  output logic sda_low,
  input logic sda
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // data changes in the low half, read back late in the high half
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    #80 scl = 1'b1;
    #160 r = sda;
    scl = 1'b0;
    #80;
  endtask
  // serves both a first and a repeated start
  task automatic start();
    sda_low = 1'b0;
    #80 scl = 1'b1;
    #160 sda_low = 1'b1;
    #160 scl = 1'b0;
    #80;
  endtask
  task automatic stop();
    sda_low = 1'b1;
    #80 scl = 1'b1;
    #160 sda_low = 1'b0;
    #160;
  endtask
  task automatic xfer(input [7:0] d, input logic ai, output [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(ai, a);
  endtask
endmodule // pscp_host_model

// ==== pscp_regs.vh ====
`ifndef PSCP_REGS_VH
`define PSCP_REGS_VH
`define PSCP_TARGET_ADDR 7'h6b
`define PSCP_MCODE_TOP 5'h01
`define PSCP_REG_STATUS 8'h00
`define PSCP_REG_MAIN 8'h01
`define PSCP_REG_INLIM 8'h02
`define PSCP_REG_OUT 8'h03
`define PSCP_MAIN_RESET 8'h60
`define PSCP_INLIM_RESET 8'h04
`define PSCP_OUT_RESET 8'h70
`define PSCP_MAIN_MASK 8'hf8
`define PSCP_INLIM_MASK 8'hef
`define PSCP_OUT_MASK 8'hf0
`define PSCP_BIT_TEST 7
`define PSCP_BIT_HOLD 6
`define PSCP_BIT_AMASK 5
`define PSCP_BIT_TOFF 4
`define PSCP_BIT_HMASK 3
`define PSCP_CLK_MHZ 25
`define PSCP_ALERT_US 125
`define PSCP_ALERT_CYC (`PSCP_ALERT_US * `PSCP_CLK_MHZ)
`endif

// ==== pscp_sync.v ====
`timescale 1ns/1ps
// two-stage synchroniser for one pin; first stage feeds only the second
module pscp_sync (
  input wire clk,
  input wire reset_n,
  input wire pin_in,
  output wire pin_sync
);
  reg meta_q;
  reg sync_q;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end
  assign pin_sync = sync_q;
endmodule // pscp_sync

// ==== pscp_top.v ====
`timescale 1ns/1ps
`include "pscp_regs.vh"
// serial target port and configuration registers
module pscp_top (
  input wire clk,
  input wire reset_n,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  output reg alert_out,
  output reg alert_oe,
  input wire [7:0] status_in,
  input wire die_hot,
  input wire output_in_regulation,
  output reg buck_enable,
  output reg bulk_pass_switch,
  output reg bulk_pass_full_on,
  output reg precharge_enable,
  output reg [2:0] input_current_sel,
  output reg [3:0] bulk_voltage_limit_sel,
  output reg [3:0] output_level_sel,
  output reg hs_mode
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_AACK = 3'h2;
  localparam [2:0] ST_WRX = 3'h3;
  localparam [2:0] ST_WACK = 3'h4;
  localparam [2:0] ST_RTX = 3'h5;
  localparam [2:0] ST_RACK = 3'h6;
  localparam [2:0] ST_SKIP = 3'h7;

  wire scl_s;
  wire sda_s;
  reg scl_q;
  reg sda_q;
  reg [2:0] state_q;
  reg [2:0] bit_q;
  reg [7:0] shift_q;
  reg rw_q;
  reg have_reg_q;
  reg [7:0] ptr_q;
  reg mcode_q;
  reg [7:0] main_q;
  reg [7:0] inlim_q;
  reg [7:0] out_q;
  reg [7:0] status_q;
  reg hot_q;
  reg alert_trig_q;
  wire alert_busy;

  // read value with reserved bits forced to zero
  function [7:0] reg_read;
    input [7:0] idx;
    begin
      case (idx)
        `PSCP_REG_STATUS: reg_read = status_in;
        `PSCP_REG_MAIN: reg_read = main_q & `PSCP_MAIN_MASK;
        `PSCP_REG_INLIM: reg_read = inlim_q & `PSCP_INLIM_MASK;
        `PSCP_REG_OUT: reg_read = out_q & `PSCP_OUT_MASK;
        default: reg_read = 8'h00;
      endcase
    end
  endfunction

  // byte the pointer selects, ready for the next read byte
  wire [7:0] rd_byte = reg_read(ptr_q);

  // pins come from the bus domain, so both go through two flops
  pscp_sync u_scl (
    .clk(clk),
    .reset_n(reset_n),
    .pin_in(scl_in),
    .pin_sync(scl_s)
  );
  pscp_sync u_sda (
    .clk(clk),
    .reset_n(reset_n),
    .pin_in(sda_in),
    .pin_sync(sda_s)
  );

  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire start_c = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_c = scl_s & scl_q & ~sda_q & sda_s;

  // edge history of the synchronised pins
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  // target protocol engine; scl is never driven, it only times us
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      bit_q <= 3'h7;
      shift_q <= 8'h00;
      rw_q <= 1'b0;
      have_reg_q <= 1'b0;
      ptr_q <= 8'h00;
      mcode_q <= 1'b0;
      hs_mode <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      main_q <= `PSCP_MAIN_RESET;
      inlim_q <= `PSCP_INLIM_RESET;
      out_q <= `PSCP_OUT_RESET;
    end else if (stop_c) begin
      state_q <= ST_IDLE;
      sda_oe <= 1'b0;
      mcode_q <= 1'b0;
      hs_mode <= 1'b0;
    end else if (start_c) begin
      // repeated start after the master code enters high-speed mode
      if (mcode_q) begin
        hs_mode <= 1'b1;
        mcode_q <= 1'b0;
      end
      state_q <= ST_ADDR;
      bit_q <= 3'h7;
      have_reg_q <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      case (state_q)
        ST_ADDR, ST_WRX: begin
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], sda_s};
            bit_q <= bit_q - 3'h1;
            if (bit_q == 3'h0) begin
              state_q <= (state_q == ST_ADDR) ? ST_AACK : ST_WACK;
            end
          end
        end
        ST_AACK: begin
          if (scl_fall && !sda_oe) begin
            if (shift_q[7:1] == `PSCP_TARGET_ADDR) begin
              rw_q <= shift_q[0];
              sda_out <= 1'b0;
              sda_oe <= 1'b1;
            end else begin
              // master code or another target: stay off the line
              if (shift_q[7:3] == `PSCP_MCODE_TOP) begin
                mcode_q <= 1'b1;
              end
              state_q <= ST_SKIP;
            end
          end else if (scl_fall && sda_oe) begin
            sda_oe <= 1'b0;
            bit_q <= 3'h7;
            if (rw_q) begin
              shift_q <= rd_byte;
              sda_out <= 1'b0;
              sda_oe <= ~rd_byte[7];
              state_q <= ST_RTX;
            end else begin
              state_q <= ST_WRX;
            end
          end
        end
        ST_WACK: begin
          if (scl_fall && !sda_oe) begin
            sda_out <= 1'b0;
            sda_oe <= 1'b1;
            if (!have_reg_q) begin
              ptr_q <= shift_q;
              have_reg_q <= 1'b1;
            end else begin
              case (ptr_q)
                `PSCP_REG_MAIN: main_q <= shift_q & `PSCP_MAIN_MASK;
                `PSCP_REG_INLIM: inlim_q <= shift_q & `PSCP_INLIM_MASK;
                `PSCP_REG_OUT: out_q <= shift_q & `PSCP_OUT_MASK;
                default: ptr_q <= ptr_q;
              endcase
              ptr_q <= ptr_q + 8'h01;
            end
          end else if (scl_fall && sda_oe) begin
            sda_oe <= 1'b0;
            bit_q <= 3'h7;
            state_q <= ST_WRX;
          end
        end
        ST_RTX: begin
          // change data only just after scl falls
          if (scl_fall) begin
            if (bit_q == 3'h0) begin
              sda_oe <= 1'b0; // release for controller ack
              state_q <= ST_RACK;
              ptr_q <= ptr_q + 8'h01;
            end else begin
              shift_q <= {shift_q[6:0], 1'b0};
              sda_oe <= ~shift_q[6];
              bit_q <= bit_q - 3'h1;
            end
          end
        end
        ST_RACK: begin
          // have_reg_q marks a seen controller ack; the msb waits for scl low
          if (scl_rise) begin
            if (sda_s) begin
              state_q <= ST_SKIP; // not acknowledged: read ends
            end else begin
              have_reg_q <= 1'b1;
            end
          end else if (scl_fall && have_reg_q) begin
            have_reg_q <= 1'b0;
            shift_q <= rd_byte;
            bit_q <= 3'h7;
            sda_oe <= ~rd_byte[7];
            state_q <= ST_RTX;
          end
        end
        ST_SKIP: begin
          sda_oe <= 1'b0;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // status change or hot-die entry starts an alert pulse
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_q <= 8'h00;
      hot_q <= 1'b0;
      alert_trig_q <= 1'b0;
    end else begin
      status_q <= status_in;
      hot_q <= die_hot;
      alert_trig_q <= ~main_q[`PSCP_BIT_AMASK] &
        ((status_q != status_in) |
         (die_hot & ~hot_q & ~main_q[`PSCP_BIT_HMASK]));
    end
  end

  pscp_alert u_alert (
    .clk(clk),
    .reset_n(reset_n),
    .trigger(alert_trig_q),
    .busy(alert_busy)
  );

  // alert pin: pulses when unmasked, and also pulled low while the output is out of regulation
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      alert_out <= 1'b0;
      alert_oe <= 1'b1;
    end else begin
      alert_out <= 1'b0;
      alert_oe <= alert_busy | ~output_in_regulation;
    end
  end

  // power path controls from the main, input limit and output configuration
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      buck_enable <= 1'b1;
      bulk_pass_switch <= 1'b0;
      bulk_pass_full_on <= 1'b0;
      precharge_enable <= 1'b0;
      input_current_sel <= 3'h0;
      bulk_voltage_limit_sel <= 4'h4;
      output_level_sel <= 4'h7;
    end else begin
      buck_enable <= 1'b1;
      bulk_pass_full_on <= main_q[`PSCP_BIT_TEST];
      precharge_enable <= main_q[`PSCP_BIT_HOLD] & ~main_q[`PSCP_BIT_TEST];
      if (main_q[`PSCP_BIT_TEST]) begin
        bulk_pass_switch <= 1'b1;
      end else if (main_q[`PSCP_BIT_HOLD]) begin
        bulk_pass_switch <= 1'b0;
      end else begin
        bulk_pass_switch <= main_q[`PSCP_BIT_TOFF] | ~die_hot;
      end
      input_current_sel <= inlim_q[7:5];
      bulk_voltage_limit_sel <= inlim_q[3:0];
      output_level_sel <= out_q[7:4];
    end
  end
endmodule // pscp_top

// ==== pscp_top_checker.sv ====
`timescale 1ns/1ps
module pscp_top_checker (
  input logic clk,
  input logic reset_n,
  input logic scl_in,
  input logic sda_in,
  input logic sda_out,
  input logic sda_oe,
  input logic alert_out,
  input logic alert_oe,
  input logic [7:0] status_in,
  input logic die_hot,
  input logic output_in_regulation,
  input logic buck_enable,
  input logic bulk_pass_switch,
  input logic bulk_pass_full_on,
  input logic precharge_enable,
  input logic [2:0] input_current_sel,
  input logic [3:0] bulk_voltage_limit_sel,
  input logic [3:0] output_level_sel,
  input logic hs_mode
);
  logic [11:0] run_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // length of the current low pulse, restarted by every trigger so retriggers never fire
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      run_q <= 12'h000;
    else if (!alert_oe || !output_in_regulation || $rose(die_hot) || status_in != $past(status_in))
      run_q <= 12'h000;
    else
      run_q <= run_q + 12'h001;
  end
  sequence s_start;
    scl_in && $fell(sda_in);
  endsequence
  sequence s_stop;
    scl_in && $rose(sda_in);
  endsequence
  AST_SDA_PULL_ONLY: assert property (sda_oe |-> sda_out == 1'b0)
    else $error("sda driven high");
  AST_ALERT_PULL_ONLY: assert property (alert_oe |-> alert_out == 1'b0)
    else $error("alert driven high");
  AST_SDA_CHANGE_LOW: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("sda changed while scl high");
  AST_START_RELEASE: assert property (s_start |-> !sda_oe [*3])
    else $error("sda pulled around a start");
  AST_HS_LEAVE: assert property (s_stop |-> ##[1:8] !hs_mode)
    else $error("high-speed mode kept after stop");
  AST_HOLD_MODE: assert property (precharge_enable && !bulk_pass_full_on |->
    buck_enable && !bulk_pass_switch)
    else $error("hold mode outputs wrong");
  AST_PULSE_LEN: assert property (run_q <= 12'd3130)
    else $error("alert pulse too long");
  AST_RESET_VALS: assert property ($rose(reset_n) |-> output_level_sel == 4'h7 &&
    bulk_voltage_limit_sel == 4'h4 && input_current_sel == 3'h0 && !hs_mode)
    else $error("wrong values after reset");
endmodule // pscp_top_checker
bind pscp_top pscp_top_checker i_chk (.*);

// ==== tb_pmic_serial_config_port.sv ====
`timescale 1ns/1ps
`include "pscp_regs.vh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; $display("unexpected %s exp %h got %h", n, e, g); end end
module tb_pmic_serial_config_port;
  logic clk, reset_n, h_scl, h_low, die_hot, oir, sda_oe, alert_oe, hs_mode;
  logic buck_enable, bulk_pass_switch, bulk_pass_full_on, precharge_enable;
  logic [7:0] status_in, v;
  logic [2:0] input_current_sel;
  logic [3:0] bulk_voltage_limit_sel, output_level_sel;
  logic [7:0] rst [1:3] = '{8'h60, 8'h04, 8'h70};
  logic [7:0] msk [1:3] = '{8'hf8, 8'hef, 8'hf0};
  int bad_count = 0;
  int checks = 0;
  wire sda = !(h_low || sda_oe);
  pscp_top i_dut (.*, .scl_in(h_scl), .sda_in(sda), .sda_out(), .alert_out(),
    .output_in_regulation(oir));
  pscp_host_model h (.scl(h_scl), .sda_low(h_low), .sda(sda));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic print_verdict();
    if (bad_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // waits, then leaves the bench just after a rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic send(input [7:0] d, input logic e);
    logic [7:0] q;
    logic a;
    h.xfer(d, 1'b1, q, a);
    `CHK("ack", e, a)
  endtask
  task automatic wr(input [7:0] r, input [7:0] d);
    h.start();
    send(8'hd6, 1'b0);
    send(r, 1'b0);
    send(d, 1'b0);
    h.stop();
    cyc(1);
  endtask
  task automatic rd(input [7:0] r, output [7:0] d);
    logic a;
    h.start();
    send(8'hd6, 1'b0);
    send(r, 1'b0);
    h.start();
    send(8'hd7, 1'b0);
    h.xfer(8'hff, 1'b1, d, a);
    h.stop();
    cyc(1);
  endtask
  // cut short a hung run: about five times the expected length of all tests
  initial begin
    #(40 * 40000);
    bad_count++;
    print_verdict();
  end
  initial begin
    reset_n = 1'b0;
    die_hot = 1'b0;
    oir = 1'b1;
    status_in = 8'h00;
    cyc(3);
    reset_n = 1'b1;
    cyc(3);
    for (int i = 1; i < 4; i++) begin
      rd(i[7:0], v);
      `CHK("reset", rst[i], v)
    end
    for (int i = 1; i < 4; i++) begin
      wr(i[7:0], 8'hff);
      rd(i[7:0], v);
      `CHK("reg", msk[i], v)
    end
    `CHK("full_on", 1'b1, bulk_pass_full_on)
    `CHK("cur_sel", 3'h7, input_current_sel)
    wr(8'h01, 8'h40);
    `CHK("precharge", 1'b1, precharge_enable)
    `CHK("switch", 1'b0, bulk_pass_switch)
    wr(8'h01, 8'h00);
    die_hot = 1'b1;
    cyc(3);
    `CHK("switch", 1'b0, bulk_pass_switch)
    `CHK("alert", 1'b1, alert_oe)
    cyc(`PSCP_ALERT_CYC - 50);
    `CHK("alert", 1'b1, alert_oe)
    cyc(60);
    `CHK("alert", 1'b0, alert_oe)
    die_hot = 1'b0;
    wr(8'h01, 8'h18);
    die_hot = 1'b1;
    cyc(3);
    `CHK("switch", 1'b1, bulk_pass_switch)
    `CHK("alert", 1'b0, alert_oe)
    die_hot = 1'b0;
    wr(8'h01, 8'h20);
    status_in = 8'h01;
    cyc(3);
    `CHK("alert", 1'b0, alert_oe)
    oir = 1'b0;
    cyc(3);
    `CHK("alert", 1'b1, alert_oe)
    oir = 1'b1;
    wr(8'h01, 8'h00);
    status_in = 8'h02;
    cyc(3);
    `CHK("alert", 1'b1, alert_oe)
    rd(8'h00, v);
    `CHK("status", 8'h02, v)
    h.start();
    send(8'hd4, 1'b1);
    h.stop();
    h.start();
    send(8'h08, 1'b1);
    h.start();
    `CHK("hs", 1'b1, hs_mode)
    send(8'hd6, 1'b0);
    h.stop();
    cyc(8);
    `CHK("hs", 1'b0, hs_mode)
    print_verdict();
  end
endmodule // tb_pmic_serial_config_port
